// ==== include/btc_if.sv ====
`timescale 1ns/1ps
interface btc_if;
  logic       address_strobe;
  logic [1:0] size_ack_pair;
  logic       bus_error_in;
  logic       halt_in;

  modport dev (
    output address_strobe,
    input  size_ack_pair,
    input  bus_error_in,
    input  halt_in
  );
  modport term (
    input  address_strobe,
    output size_ack_pair,
    output bus_error_in,
    output halt_in
  );
endinterface

// ==== include/btc_pkg.sv ====
package btc_pkg;
  // termination outcomes
  typedef enum logic [2:0] {
    BTC_OUT_NONE   = 3'b000,
    BTC_OUT_NORMAL = 3'b001,
    BTC_OUT_HALT   = 3'b010,
    BTC_OUT_BUS_ERROR_IN   = 3'b011,
    BTC_OUT_RETRY  = 3'b100
  } btc_outcome_t;

  // device-side cycle states, gray along idle-wait-check-close
  typedef enum logic [2:0] {
    BTC_ST_IDLE   = 3'b000,
    BTC_ST_WAIT   = 3'b001,
    BTC_ST_CHECK  = 3'b011,
    BTC_ST_CLOSE  = 3'b010,
    BTC_ST_HALTED = 3'b110,
    BTC_ST_RETRY  = 3'b111
  } btc_state_t;

  // partner-side response modes
  typedef enum logic [2:0] {
    BTC_RSP_NORMAL  = 3'b000,
    BTC_RSP_HALT    = 3'b001,
    BTC_RSP_BUS_ERROR_IN    = 3'b010,
    BTC_RSP_LATEBE  = 3'b011,
    BTC_RSP_RETRY   = 3'b100,
    BTC_RSP_LATERT  = 3'b101,
    BTC_RSP_TIMEOUT = 3'b110
  } btc_rsp_t;

  // states between first and second sample (state n to n+2)
  localparam int unsigned BTC_SAMPLE_GAP   = 2;
  localparam logic [1:0]  BTC_ACK_NONE     = 2'h0;
  localparam logic [1:0]  BTC_ACK_RST      = 2'h0;
  localparam int unsigned BTC_WDOG_DEFAULT = 16;
  localparam int unsigned BTC_WAIT_DEFAULT = 1;
endpackage

// ==== rtl/btc_device.sv ====
`timescale 1ns/1ps
module btc_device
  import btc_pkg::*;
#(
  parameter int unsigned ADDR_W = 32,
  parameter int unsigned FC_W   = 3
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  btc_if.dev                     bus,
  input  wire logic              req_valid,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [FC_W-1:0]   req_fc,
  input  wire logic [1:0]        req_size,
  input  wire logic              req_prefetch,
  input  wire logic              req_cache_fill,
  input  wire logic              use_prefetch,
  input  wire logic              flow_change,
  output logic                   req_ready,
  output logic                   cycle_done,
  output btc_outcome_t           outcome,
  output logic                   bus_error_exc,
  output logic                   abort_instr,
  output logic                   cache_invalidate,
  output logic                   prefetch_err_pending,
  output logic                   halted,
  output logic                   retrying,
  output logic [ADDR_W-1:0]      cur_addr,
  output logic [FC_W-1:0]        cur_fc,
  output logic [1:0]             cur_size
);
  // ----------------------------------------
  // state and captured access
  // ----------------------------------------
  btc_state_t   state_q, state_d;
  logic [1:0]   ack_n_q;
  logic         be_n_q, halt_n_q;
  logic         pf_q, fill_q;
  logic         as_q;
  logic         pend_q;
  btc_outcome_t out_q;
  logic         done_q, exc_q, inv_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire ack_now   = bus.size_ack_pair != BTC_ACK_NONE;
  wire ack_seen  = ack_n_q != BTC_ACK_NONE;
  wire be_now    = bus.bus_error_in;
  wire halt_now  = bus.halt_in;
  // first sample resolved: ack or error seen at state n
  wire start_chk = ack_now | be_now;
  // combine n and n+2 samples
  wire be_any    = be_n_q | be_now;
  wire halt_any  = halt_n_q | halt_now;
  wire is_retry  = be_any & halt_any;
  wire is_bus_error_in   = be_any & ~halt_any;
  wire is_halt   = ~be_any & halt_n_q & ack_seen;
  // priority: retry over error over halt over normal
  wire btc_outcome_t dec_out = is_retry ? BTC_OUT_RETRY :
                               is_bus_error_in  ? BTC_OUT_BUS_ERROR_IN  :
                               is_halt  ? BTC_OUT_HALT  :
                                          BTC_OUT_NORMAL;
  wire inputs_clear = ~be_now & ~halt_now;
  wire bus_error_in_close   = state_q == BTC_ST_CHECK && dec_out == BTC_OUT_BUS_ERROR_IN;
  wire exc_now      = bus_error_in_close & ~pf_q;
  wire pend_set     = bus_error_in_close & pf_q;
  // prefetched error fires only when used and not flushed
  wire pend_fire    = pend_q & use_prefetch & ~flow_change;

  always_comb begin
    state_d = state_q;
    case (state_q)
      BTC_ST_IDLE: begin
        if (req_valid & ~halt_now) begin
          state_d = BTC_ST_WAIT;
        end
      end
      BTC_ST_WAIT: begin
        if (start_chk) begin
          state_d = BTC_ST_CHECK;
        end
      end
      BTC_ST_CHECK: begin
        state_d = BTC_ST_CLOSE;
      end
      BTC_ST_CLOSE: begin
        if (out_q == BTC_OUT_RETRY) begin
          state_d = BTC_ST_RETRY;
        end else if (out_q == BTC_OUT_HALT || halt_now) begin
          state_d = BTC_ST_HALTED;
        end else begin
          state_d = BTC_ST_IDLE;
        end
      end
      BTC_ST_HALTED: begin
        if (~halt_now) begin
          state_d = BTC_ST_IDLE;
        end
      end
      BTC_ST_RETRY: begin
        if (inputs_clear) begin
          state_d = BTC_ST_WAIT;
        end
      end
      default: begin
        state_d = BTC_ST_IDLE;
      end
    endcase
  end

  wire take_req = state_q == BTC_ST_IDLE && state_d == BTC_ST_WAIT;
  wire as_d     = state_d == BTC_ST_WAIT || state_d == BTC_ST_CHECK;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q  <= BTC_ST_IDLE;
      ack_n_q  <= BTC_ACK_RST;
      be_n_q   <= 1'b0;
      halt_n_q <= 1'b0;
      as_q     <= 1'b0;
      out_q    <= BTC_OUT_NONE;
      done_q   <= 1'b0;
      exc_q    <= 1'b0;
      inv_q    <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      as_q    <= as_d;
      if (state_q == BTC_ST_WAIT && start_chk) begin
        ack_n_q  <= bus.size_ack_pair;
        be_n_q   <= be_now;
        halt_n_q <= halt_now;
      end
      if (state_q == BTC_ST_CHECK) begin
        out_q <= dec_out;
      end
      done_q <= state_q == BTC_ST_CHECK;
      exc_q  <= exc_now | pend_fire;
      inv_q  <= bus_error_in_close & fill_q;
    end
  end

  // access information kept for an identical retry
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur_addr <= '0;
      cur_fc   <= '0;
      cur_size <= 2'h0;
      pf_q     <= 1'b0;
      fill_q   <= 1'b0;
    end else if (clk_en && take_req) begin
      cur_addr <= req_addr;
      cur_fc   <= req_fc;
      cur_size <= req_size;
      pf_q     <= req_prefetch;
      fill_q   <= req_cache_fill;
    end
  end

  // pending prefetch fault; a new one wins over a flush
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
    end else if (clk_en) begin
      if (pend_set) begin
        pend_q <= 1'b1;
      end else if (flow_change | use_prefetch) begin
        pend_q <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_ready            <= 1'b0;
      halted               <= 1'b0;
      retrying             <= 1'b0;
    end else if (clk_en) begin
      req_ready            <= state_d == BTC_ST_IDLE;
      halted               <= state_d == BTC_ST_HALTED;
      retrying             <= state_d == BTC_ST_RETRY;
    end
  end

  assign bus.address_strobe   = as_q;
  assign cycle_done           = done_q;
  assign outcome              = out_q;
  assign bus_error_exc        = exc_q;
  assign abort_instr          = exc_q;
  assign cache_invalidate     = inv_q;
  assign prefetch_err_pending = pend_q;
endmodule

// ==== rtl/btc_term.sv ====
`timescale 1ns/1ps
module btc_term
  import btc_pkg::*;
#(
  parameter int unsigned WDOG_CYC = BTC_WDOG_DEFAULT,
  parameter int unsigned WAIT_CYC = BTC_WAIT_DEFAULT
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  btc_if.term             bus,
  input  wire logic       populated,
  input  wire btc_rsp_t   rsp_mode,
  input  wire logic [1:0] ack_code,
  output logic            busy
);
  // ----------------------------------------
  // response sequencer
  // ----------------------------------------
  logic [1:0]  ack_q;
  logic        be_q, halt_q;
  logic [15:0] cnt_q;
  logic        late_q;
  logic        as_seen_q;

  wire as_rise  = bus.address_strobe & ~as_seen_q;
  wire wait_hit = cnt_q == 16'(WAIT_CYC);
  wire wdog_hit = cnt_q == 16'(WDOG_CYC);
  wire early    = rsp_mode == BTC_RSP_LATEBE || rsp_mode == BTC_RSP_LATERT;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q     <= BTC_ACK_RST;
      be_q      <= 1'b0;
      halt_q    <= 1'b0;
      cnt_q     <= 16'h0000;
      late_q    <= 1'b0;
      as_seen_q <= 1'b0;
      busy      <= 1'b0;
    end else if (clk_en) begin
      as_seen_q <= bus.address_strobe;
      late_q    <= 1'b0;
      if (!bus.address_strobe) begin
        // release once strobe drops (halt one clock later after an error), before next cycle samples
        ack_q  <= BTC_ACK_NONE;
        be_q   <= 1'b0;
        halt_q <= be_q ? halt_q : 1'b0;
        cnt_q  <= 16'h0000;
        busy   <= 1'b0;
        if (!be_q) begin
          halt_q <= 1'b0;
        end
      end else begin
        busy  <= 1'b1;
        if (!as_rise) begin
          cnt_q <= cnt_q + 16'h0001;
        end
        if (!populated && wdog_hit) begin
          be_q <= 1'b1;
        end else if (populated && wait_hit) begin
          case (rsp_mode)
            BTC_RSP_NORMAL: ack_q <= ack_code;
            BTC_RSP_HALT: begin
              ack_q  <= ack_code;
              halt_q <= 1'b1;
            end
            BTC_RSP_BUS_ERROR_IN:  be_q <= 1'b1;
            BTC_RSP_RETRY: begin
              be_q   <= 1'b1;
              halt_q <= 1'b1;
            end
            default: ack_q <= ack_code;
          endcase
          late_q <= early;
        end
        // late error one clock after ack, held to cycle end
        if (late_q) begin
          be_q <= 1'b1;
          if (rsp_mode == BTC_RSP_LATERT) begin
            halt_q <= 1'b1;
          end
        end
      end
    end
  end

  assign bus.size_ack_pair = ack_q;
  assign bus.bus_error_in  = be_q;
  assign bus.halt_in       = halt_q;
endmodule

// ==== test/btc_props.sv ====
`timescale 1ns/1ps
module btc_props (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       address_strobe,
  input wire logic [1:0] size_ack_pair,
  input wire logic       bus_error_in,
  input wire logic       halt_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // ---------------------------------------------------------------
  // cycle endings
  // ---------------------------------------------------------------
  norm_end_a: assert property (
    address_strobe && size_ack_pair != 2'h0 && !bus_error_in && !halt_in
    ##1 (!bus_error_in && !halt_in) |-> ##[1:3] !address_strobe)
    else $error("normal cycle did not close");
  bus_error_in_end_a: assert property (
    address_strobe && bus_error_in && !halt_in |-> ##[1:3] !address_strobe)
    else $error("bus error did not close cycle");
  retry_end_a: assert property (
    address_strobe && bus_error_in && halt_in |-> ##[1:3] !address_strobe)
    else $error("retry did not close cycle");
  late_err_a: assert property (
    address_strobe && size_ack_pair != 2'h0 && !halt_in ##1 bus_error_in
    |-> ##[1:2] !address_strobe)
    else $error("late bus error not honoured");
  // halt alone or silence must never end a cycle
  no_early_end_a: assert property (
    (address_strobe && size_ack_pair == 2'h0 && !bus_error_in) [*2]
    |=> address_strobe)
    else $error("cycle ended without ack or error");

  // ---------------------------------------------------------------
  // cycle starts and release order
  // ---------------------------------------------------------------
  halt_block_a: assert property (
    $rose(address_strobe) |-> !$past(halt_in))
    else $error("cycle started while halt held");
  clear_next_a: assert property (
    $rose(address_strobe) |-> size_ack_pair == 2'h0 && !bus_error_in)
    else $error("stale termination at cycle start");
  halt_after_err_a: assert property (
    $fell(halt_in) |-> !bus_error_in)
    else $error("halt released before bus error");
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  import btc_pkg::*;
  logic         clock, rstn, clk_en, req_valid, req_prefetch, req_cache_fill;
  logic         use_prefetch, flow_change, populated, busy;
  logic         req_ready, cycle_done, bus_error_exc, abort_instr, cache_invalidate;
  logic         prefetch_err_pending, halted, retrying, seen;
  logic [31:0]  req_addr, cur_addr;
  logic [2:0]   req_fc, cur_fc;
  logic [1:0]   req_size, cur_size, ack_code;
  btc_rsp_t     rsp_mode;
  btc_outcome_t outcome, exp;
  int           mismatches, n_checks, cycles;
  btc_rsp_t     modes [7] = '{BTC_RSP_NORMAL, BTC_RSP_HALT, BTC_RSP_BUS_ERROR_IN, BTC_RSP_LATEBE,
                              BTC_RSP_RETRY, BTC_RSP_LATERT, BTC_RSP_TIMEOUT};
  btc_outcome_t outs [7]  = '{BTC_OUT_NORMAL, BTC_OUT_HALT, BTC_OUT_BUS_ERROR_IN, BTC_OUT_BUS_ERROR_IN,
                              BTC_OUT_RETRY, BTC_OUT_RETRY, BTC_OUT_BUS_ERROR_IN};

  btc_if bus_if ();
  btc_device i_btc_device (.clock(clock), .rstn(rstn), .clk_en(clk_en), .bus(bus_if.dev),
    .req_valid(req_valid), .req_addr(req_addr), .req_fc(req_fc), .req_size(req_size),
    .req_prefetch(req_prefetch), .req_cache_fill(req_cache_fill),
    .use_prefetch(use_prefetch), .flow_change(flow_change), .req_ready(req_ready),
    .cycle_done(cycle_done), .outcome(outcome), .bus_error_exc(bus_error_exc),
    .abort_instr(abort_instr), .cache_invalidate(cache_invalidate),
    .prefetch_err_pending(prefetch_err_pending), .halted(halted), .retrying(retrying),
    .cur_addr(cur_addr), .cur_fc(cur_fc), .cur_size(cur_size));
  // short watchdog keeps the timeout case brief
  btc_term #(.WDOG_CYC(6), .WAIT_CYC(2)) i_btc_term (.clock(clock), .rstn(rstn),
    .clk_en(clk_en), .bus(bus_if.term), .populated(populated), .rsp_mode(rsp_mode),
    .ack_code(ack_code), .busy(busy));
  btc_props u_props (.clock(clock), .rstn(rstn), .address_strobe(bus_if.address_strobe),
    .size_ack_pair(bus_if.size_ack_pair), .bus_error_in(bus_if.bus_error_in),
    .halt_in(bus_if.halt_in));

  always #2 clock = ~clock;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, e, got);
    end
  endtask

  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  task automatic wait_for(input int which);
    int i;
    i = 0;
    tick;
    while (i < 300 && (which == 0 ? cycle_done !== 1'b1 : which == 1 ? req_ready !== 1'b1
                       : halted !== 1'b0)) begin
      tick;
      i++;
    end
    check("wait bound", 32'h0000_0001, 32'(i < 300));
  endtask

  // one bus access through the device, back when it closes
  task automatic access(input btc_rsp_t m, input logic pf, input logic fill,
                        input logic [31:0] a);
    wait_for(1);
    rsp_mode = m;
    populated = (m != BTC_RSP_TIMEOUT);
    req_prefetch = pf;
    req_cache_fill = fill;
    req_addr = a;
    req_valid = 1'b1;
    tick;
    req_valid = 1'b0;
    wait_for(0);
  endtask

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    {req_valid, req_prefetch, req_cache_fill, use_prefetch, flow_change} = '0;
    populated = 1'b1;
    req_addr = 32'h0000_0000;
    req_fc = 3'h5;
    req_size = 2'h2;
    ack_code = 2'h1;
    rsp_mode = BTC_RSP_NORMAL;
    repeat (3) @(posedge clock);
    #1;
    rstn = 1'b1;
    check("reset outcome", 32'(BTC_OUT_NONE), 32'(outcome));
    check("reset ready", 32'h0000_0000, 32'(req_ready));
    for (int k = 0; k < 7; k++) begin
      exp = outs[k];
      ack_code = 2'(k % 3 + 1);
      access(modes[k], 1'b0, modes[k] == BTC_RSP_BUS_ERROR_IN, 32'h1000_0000 + 32'(k));
      check("outcome", 32'(exp), 32'(outcome));
      check("exception", 32'(exp == BTC_OUT_BUS_ERROR_IN), 32'(bus_error_exc));
      check("abort", 32'(exp == BTC_OUT_BUS_ERROR_IN), 32'(abort_instr));
      check("invalidate", 32'(modes[k] == BTC_RSP_BUS_ERROR_IN), 32'(cache_invalidate));
      check("busy", 32'h0000_0001, 32'(busy));
      if (exp == BTC_OUT_RETRY) begin
        tick;
        check("retrying", 32'h0000_0001, 32'(retrying));
        rsp_mode = BTC_RSP_NORMAL;
        wait_for(0);
        check("retry outcome", 32'(BTC_OUT_NORMAL), 32'(outcome));
        check("retry addr", 32'h1000_0000 + 32'(k), cur_addr);
        check("retry fc", 32'h0000_0005, 32'(cur_fc));
        check("retry size", 32'h0000_0002, 32'(cur_size));
      end
      if (exp == BTC_OUT_HALT) begin
        tick;
        check("halted", 32'h0000_0001, 32'(halted));
        check("ready", 32'h0000_0000, 32'(req_ready));
        rsp_mode = BTC_RSP_NORMAL;
        wait_for(2);
      end
    end
    // prefetch error is deferred until the word is used, or dropped on a branch
    for (int f = 0; f < 2; f++) begin
      access(BTC_RSP_BUS_ERROR_IN, 1'b1, 1'b0, 32'h2000_0000);
      check("pf exc", 32'h0000_0000, 32'(bus_error_exc));
      tick;
      check("pending", 32'h0000_0001, 32'(prefetch_err_pending));
      use_prefetch = (f == 0);
      flow_change = (f == 1);
      // enable low must freeze the pending fault
      clk_en = 1'b0;
      tick;
      check("frozen pending", 32'h0000_0001, 32'(prefetch_err_pending));
      check("frozen exc", 32'h0000_0000, 32'(bus_error_exc));
      clk_en = 1'b1;
      seen = 1'b0;
      repeat (3) begin
        tick;
        use_prefetch = 1'b0;
        flow_change = 1'b0;
        seen = seen | (bus_error_exc === 1'b1);
      end
      check("deferred exc", 32'(f == 0), 32'(seen));
      check("pending clear", 32'h0000_0000, 32'(prefetch_err_pending));
    end
    tally_and_finish;
  end
endmodule
